/* File: inc/cip_pkg.sv */
package cip_pkg;

    localparam int NUM_REQ = 8;
    localparam int LVL_W = 3;

    // apb word offsets of the two device ports
    localparam logic [11:0] OFF_CMD = 12'h000;
    localparam logic [11:0] OFF_MASK = 12'h004;

    // command byte fields on the register_select_line low port
    localparam int BIT_INIT = 4;
    localparam int BIT_CMD3 = 3;
    localparam int BIT_POLL = 2;
    localparam int BIT_RDSEL = 1;
    localparam int BIT_RDISR = 0;
    localparam int BIT_EOS = 5;
    localparam int BIT_SPEC = 6;
    localparam int BIT_SINGLE = 1;

    // acknowledge answer bytes
    localparam logic [7:0] CALL_OPCODE = 8'hcd;
    localparam logic [2:0] IDLE_LVL = 3'h7;

    // reset values, and ACK_LAST, the count of the third acknowledge pulse
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_CASCADE = 8'h00;
    localparam logic [7:0] RST_VEC_HI = 8'h00;
    localparam logic [2:0] RST_VEC_LO = 3'h0;
    localparam logic [1:0] ACK_LAST = 2'h2;

    typedef enum logic [2:0] {
        INIT_READY = 3'b001,
        INIT_VECTOR = 3'b010,
        INIT_CASCADE = 3'b100
    } cip_init_t;

    typedef struct packed {
        logic present;
        logic [3:0] pad;
        logic [2:0] lvl;
    } cip_poll_word_t;

endpackage

/* File: core/cip_req_latch.sv */
`timescale 1ns/10ps

module cip_req_latch #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk, // system clock
    input wire logic reset, // synchronous, active high
    input wire logic [WIDTH-1:0] req_in, // raw request inputs
    input wire logic [WIDTH-1:0] clr, // acknowledged bits to drop
    output logic [WIDTH-1:0] latched // request_latch_register
);

    logic [WIDTH-1:0] prev_ff;
    logic [WIDTH-1:0] latched_ff;

    assign latched = latched_ff;

    ////////////////////////////////////////////////////////////////////////
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            wire rise = req_in[gi] & ~prev_ff[gi];
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    prev_ff[gi] <= 1'b0;
                    latched_ff[gi] <= 1'b0;
                end else begin
                    prev_ff[gi] <= req_in[gi];
                    // a fresh edge beats an acknowledge clear in the same cycle
                    latched_ff[gi] <= rise | (latched_ff[gi] & ~clr[gi]);
                end
            end
        end
    endgenerate

endmodule

/* File: core/cip_prio.sv */
`timescale 1ns/10ps

module cip_prio #(
    parameter int WIDTH = 8,
    parameter int LW = 3
) (
    input wire logic [WIDTH-1:0] req, // latched requests
    input wire logic [WIDTH-1:0] mask, // mask bits
    input wire logic [WIDTH-1:0] insvc, // in-service bits
    output logic win_valid, // an unmasked request outranks service
    output logic [LW-1:0] win_lvl, // its level, 0 highest
    output logic svc_valid, // any level in service
    output logic [LW-1:0] svc_lvl // highest level in service
);

    logic [WIDTH-1:0] cand;
    logic [WIDTH-1:0] above;

    ////////////////////////////////////////////////////////////////////////
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_cell
            // a level is blocked by service at its own or a higher level
            assign above[gi] = |insvc[gi:0];
            assign cand[gi] = req[gi] & ~mask[gi] & ~above[gi];
        end
    endgenerate

    assign win_valid = |cand;
    assign svc_valid = |insvc;

    always_comb begin
        win_lvl = cip_pkg::IDLE_LVL;
        svc_lvl = cip_pkg::IDLE_LVL;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (cand[i]) begin
                win_lvl = LW'(i);
            end
            if (insvc[i]) begin
                svc_lvl = LW'(i);
            end
        end
    end

endmodule

/* File: core/cip_poll_cascade.sv */
`timescale 1ns/10ps

module cip_poll_cascade #(
    parameter int NUM_REQ = cip_pkg::NUM_REQ
) (
    input wire logic core_clk, // system clock, 100 MHz
    input wire logic reset, // synchronous, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic [NUM_REQ-1:0] request_input, // request_input lines
    input wire logic master_select_pin, // high: cascade master
    input wire logic acknowledge_strobe, // one-cycle acknowledge pulse
    input wire logic [2:0] cascade_id_in, // cascade_id_lines level seen
    output logic [2:0] cascade_id_out, // cascade_id_lines drive value
    output logic cascade_id_oe, // high while driving cascade_id_lines
    output logic [7:0] ack_data, // acknowledge answer byte
    output logic ack_data_oe, // one-cycle strobe: ack_data valid
    output logic int_out // interrupt request output
);

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [NUM_REQ-1:0] svc_ff;
    logic [7:0] mask_ff;
    logic [7:0] cascade_cfg_ff;
    logic [7:0] vec_hi_ff;
    logic [2:0] vec_lo_ff;
    logic single_ff;
    logic rd_svc_ff;
    logic poll_armed_ff;
    logic poll_hit_ff;
    logic [2:0] poll_lvl_ff;
    cip_pkg::cip_init_t init_ff;
    logic [1:0] ack_cnt_ff;
    logic [2:0] ack_lvl_ff;
    logic ack_to_slave_ff;
    logic ack_owner_ff;
    logic master_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [2:0] cas_out_ff;
    logic cas_oe_ff;
    logic [7:0] ack_data_ff;
    logic ack_oe_ff;
    logic int_ff;

    logic [NUM_REQ-1:0] req_latched;
    logic win_valid;
    logic [2:0] win_lvl;
    logic svc_valid;
    logic [2:0] svc_lvl;

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign cascade_id_out = cas_out_ff;
    assign cascade_id_oe = cas_oe_ff;
    assign ack_data = ack_data_ff;
    assign ack_data_oe = ack_oe_ff;
    assign int_out = int_ff;

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    wire is_cmd = paddr == cip_pkg::OFF_CMD;
    wire is_mask = paddr == cip_pkg::OFF_MASK;
    wire addr_ok = is_cmd | is_mask;
    wire access_first = psel & penable & ~pready_ff;
    wire done = psel & penable & pready_ff;
    wire wr_done = done & pwrite & addr_ok;
    wire [7:0] wd = pwdata[7:0];
    wire cmd_wr = wr_done & is_cmd;
    wire mask_wr = wr_done & is_mask;
    wire init_wr = cmd_wr & wd[cip_pkg::BIT_INIT];
    wire cmd3_wr = cmd_wr & ~wd[cip_pkg::BIT_INIT] & wd[cip_pkg::BIT_CMD3];
    wire cmd2_wr = cmd_wr & ~wd[cip_pkg::BIT_INIT] & ~wd[cip_pkg::BIT_CMD3];
    wire poll_cmd = cmd3_wr & wd[cip_pkg::BIT_POLL] & ~wd[cip_pkg::BIT_RDSEL] &
        ~wd[cip_pkg::BIT_RDISR];
    wire rdsel_cmd = cmd3_wr & ~wd[cip_pkg::BIT_POLL] & wd[cip_pkg::BIT_RDSEL];
    wire eos_cmd = cmd2_wr & wd[cip_pkg::BIT_EOS];
    wire [2:0] eos_lvl = wd[cip_pkg::BIT_SPEC] ? wd[2:0] : svc_lvl;
    // the poll word is frozen at the first access cycle; the service bit is set
    // from that frozen level so the returned word and the state agree
    wire poll_rd_done = done & ~pwrite & is_cmd & poll_armed_ff;

    ////////////////////////////////////////////////////////////////////////
    // read mux
    cip_pkg::cip_poll_word_t poll_word;
    assign poll_word.present = win_valid;
    assign poll_word.pad = 4'h0;
    assign poll_word.lvl = win_valid ? win_lvl : cip_pkg::IDLE_LVL;

    wire [7:0] status_word = rd_svc_ff ? svc_ff : req_latched;
    wire [7:0] cmd_word = poll_armed_ff ? poll_word : status_word;
    wire [7:0] rd_byte = is_mask ? mask_ff : cmd_word;
    wire [31:0] nxt_prdata = addr_ok ? {24'h000000, rd_byte} : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // cascade roles
    wire is_master = master_ff;
    wire ack_pulse = acknowledge_strobe;
    wire ack_first = ack_pulse & (ack_cnt_ff == 2'h0);
    wire ack_second = ack_pulse & (ack_cnt_ff == 2'h1);
    wire ack_third = ack_pulse & (ack_cnt_ff == cip_pkg::ACK_LAST);
    wire win_to_slave = is_master & ~single_ff & cascade_cfg_ff[win_lvl];
    wire id_match = cascade_id_in == cascade_cfg_ff[2:0];
    wire owner_now = is_master ? ~ack_to_slave_ff : id_match;
    wire [7:0] vec_lo_byte = {vec_lo_ff, ack_lvl_ff, 2'b00};

    // who takes the winning level into service, and when
    wire master_take = ack_first & is_master & win_valid;
    wire slave_take = ack_second & ~is_master & id_match;
    wire poll_take = poll_rd_done & poll_hit_ff;

    logic [NUM_REQ-1:0] svc_set;
    logic [NUM_REQ-1:0] svc_clr;
    logic [NUM_REQ-1:0] req_clr;

    always_comb begin
        svc_set = '0;
        svc_clr = '0;
        if (master_take) begin
            svc_set[win_lvl] = 1'b1;
        end
        if (slave_take) begin
            svc_set[ack_lvl_ff] = 1'b1;
        end
        if (poll_take) begin
            svc_set[poll_lvl_ff] = 1'b1;
        end
        if (eos_cmd & (wd[cip_pkg::BIT_SPEC] | svc_valid)) begin
            svc_clr[eos_lvl] = 1'b1;
        end
        req_clr = svc_set;
    end

    wire [NUM_REQ-1:0] nxt_svc = (svc_ff & ~svc_clr) | svc_set;

    ////////////////////////////////////////////////////////////////////////
    // request latch and resolver
    cip_req_latch #(
        .WIDTH(NUM_REQ)
    ) u_latch (
        .core_clk(core_clk),
        .reset(reset),
        .req_in(request_input),
        .clr(req_clr),
        .latched(req_latched)
    );

    cip_prio #(
        .WIDTH(NUM_REQ),
        .LW(3)
    ) u_prio (
        .req(req_latched),
        .mask(mask_ff),
        .insvc(svc_ff),
        .win_valid(win_valid),
        .win_lvl(win_lvl),
        .svc_valid(svc_valid),
        .svc_lvl(svc_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus answer
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= access_first;
            pslverr_ff <= access_first & ~addr_ok;
            if (access_first & ~pwrite) begin
                prdata_ff <= nxt_prdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // poll and read selection
    always_ff @(posedge core_clk) begin
        if (reset) begin
            poll_armed_ff <= 1'b0;
            poll_hit_ff <= 1'b0;
            poll_lvl_ff <= cip_pkg::IDLE_LVL;
            rd_svc_ff <= 1'b0;
        end else begin
            if (access_first & ~pwrite & is_cmd) begin
                poll_hit_ff <= win_valid;
                poll_lvl_ff <= win_lvl;
            end
            // a poll covers one read only; the host must re-arm it
            if (poll_cmd) begin
                poll_armed_ff <= 1'b1;
            end else if (poll_rd_done | init_wr) begin
                poll_armed_ff <= 1'b0;
            end
            if (init_wr) begin
                rd_svc_ff <= 1'b0;
            end else if (rdsel_cmd) begin
                rd_svc_ff <= wd[cip_pkg::BIT_RDISR];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // setup words and mask; each device holds its own copy
    always_ff @(posedge core_clk) begin
        if (reset) begin
            init_ff <= cip_pkg::INIT_READY;
            mask_ff <= cip_pkg::RST_MASK;
            cascade_cfg_ff <= cip_pkg::RST_CASCADE;
            vec_hi_ff <= cip_pkg::RST_VEC_HI;
            vec_lo_ff <= cip_pkg::RST_VEC_LO;
            single_ff <= 1'b1;
        end else if (init_wr) begin
            init_ff <= cip_pkg::INIT_VECTOR;
            mask_ff <= cip_pkg::RST_MASK;
            vec_lo_ff <= wd[7:5];
            single_ff <= wd[cip_pkg::BIT_SINGLE];
        end else if (mask_wr) begin
            case (init_ff)
                cip_pkg::INIT_VECTOR: begin
                    vec_hi_ff <= wd;
                    init_ff <= single_ff ? cip_pkg::INIT_READY : cip_pkg::INIT_CASCADE;
                end
                cip_pkg::INIT_CASCADE: begin
                    cascade_cfg_ff <= wd;
                    init_ff <= cip_pkg::INIT_READY;
                end
                cip_pkg::INIT_READY: begin
                    mask_ff <= wd;
                end
                default: begin
                    init_ff <= cip_pkg::INIT_READY;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // service bits
    always_ff @(posedge core_clk) begin
        if (reset) begin
            svc_ff <= '0;
        end else if (init_wr) begin
            svc_ff <= '0;
        end else begin
            svc_ff <= nxt_svc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // acknowledge sequence: call, low vector byte, high vector byte
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ack_cnt_ff <= 2'h0;
            ack_lvl_ff <= cip_pkg::IDLE_LVL;
            ack_to_slave_ff <= 1'b0;
            ack_owner_ff <= 1'b0;
            master_ff <= 1'b0;
        end else begin
            master_ff <= master_select_pin;
            if (ack_pulse) begin
                ack_cnt_ff <= ack_third ? 2'h0 : ack_cnt_ff + 2'h1;
            end
            if (ack_first) begin
                // slaves latch their winner too; only the addressed one takes it into service
                ack_lvl_ff <= win_valid ? win_lvl : cip_pkg::IDLE_LVL;
                ack_to_slave_ff <= win_valid & win_to_slave;
            end
            if (ack_second) begin
                ack_owner_ff <= owner_now;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ack_data_ff <= 8'h00;
            ack_oe_ff <= 1'b0;
        end else begin
            ack_oe_ff <= 1'b0;
            if (ack_first & is_master) begin
                ack_data_ff <= cip_pkg::CALL_OPCODE;
                ack_oe_ff <= 1'b1;
            end else if (ack_second & owner_now) begin
                ack_data_ff <= vec_lo_byte;
                ack_oe_ff <= 1'b1;
            end else if (ack_third & ack_owner_ff) begin
                ack_data_ff <= vec_hi_ff;
                ack_oe_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cascade lines and interrupt output
    // the id stays on the lines until the next first pulse that hands a level to a
    // slave, so slaves that sample late still see the right owner during pulses two and three
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cas_out_ff <= 3'h0;
            cas_oe_ff <= 1'b0;
            int_ff <= 1'b0;
        end else begin
            cas_oe_ff <= master_select_pin;
            if (ack_first & win_valid & win_to_slave) begin
                cas_out_ff <= win_lvl;
            end
            // the same resolver serves master and slave; a slave's output feeds
            // one master input, giving eight slaves of eight levels at most
            int_ff <= win_valid;
        end
    end

endmodule

/* File: tb/cip_poll_cascade_monitor.sv */
`timescale 1ns/10ps

module cip_poll_cascade_monitor #(
    parameter int NUM_REQ = cip_pkg::NUM_REQ
) (
    input wire logic core_clk, // clock
    input wire logic reset, // sync reset
    input wire logic psel, // apb
    input wire logic penable, // apb
    input wire logic pwrite, // apb
    input wire logic [11:0] paddr, // apb
    input wire logic [31:0] pwdata, // apb
    input wire logic [31:0] prdata, // apb
    input wire logic pready, // apb
    input wire logic pslverr, // apb
    input wire logic [NUM_REQ-1:0] request_input, // requests
    input wire logic master_select_pin, // role
    input wire logic acknowledge_strobe, // ack pulse
    input wire logic [2:0] cascade_id_in, // cascade seen
    input wire logic [2:0] cascade_id_out, // cascade drive
    input wire logic cascade_id_oe, // cascade enable
    input wire logic [7:0] ack_data, // ack byte
    input wire logic ack_data_oe, // ack valid
    input wire logic int_out // interrupt
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////
    // poll arming as the host sees it; any later command access ends it
    logic armed_ff;
    logic nxt_armed;
    wire logic done = psel && penable && pready;
    wire logic cmd_hit = done && paddr == cip_pkg::OFF_CMD;
    wire logic poll_rd = armed_ff && cmd_hit && !pwrite;
    assign nxt_armed = cmd_hit ? (pwrite && pwdata[4:0] == 5'h0c) : armed_ff;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            armed_ff <= 1'b0;
        end else begin
            armed_ff <= nxt_armed;
        end
    end

    ////////////////////////////////////////////////////////////////
    property p_wait_state;
        psel && penable && !pready |=> pready;
    endproperty
    a_wait_state: assert property (p_wait_state) else $error("no ready after one wait");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    property p_slverr;
        pready |-> pslverr == !(paddr == cip_pkg::OFF_CMD || paddr == cip_pkg::OFF_MASK);
    endproperty
    a_slverr: assert property (p_slverr) else $error("error flag wrong");
    property p_poll_empty;
        poll_rd && !prdata[7] |-> prdata[2:0] == cip_pkg::IDLE_LVL;
    endproperty
    a_poll_empty: assert property (p_poll_empty) else $error("empty poll level wrong");
    property p_poll_pad;
        poll_rd |-> prdata[31:3] == {24'h0, prdata[7], 4'h0};
    endproperty
    a_poll_pad: assert property (p_poll_pad) else $error("poll word layout wrong");
    property p_ack_cause;
        ack_data_oe |-> $past(acknowledge_strobe);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack byte without pulse");
    property p_ack_single;
        ack_data_oe |=> !ack_data_oe;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack valid too long");
    property p_casc_oe;
        !$past(reset) |-> cascade_id_oe == $past(master_select_pin);
    endproperty
    a_casc_oe: assert property (p_casc_oe) else $error("cascade enable wrong");
    property p_read_upper;
        pready && !pwrite |-> prdata[31:8] == 24'h0;
    endproperty
    a_read_upper: assert property (p_read_upper) else $error("read upper bits set");
endmodule

bind cip_poll_cascade cip_poll_cascade_monitor #(.NUM_REQ(NUM_REQ)) u_mon (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .request_input(request_input), .master_select_pin(master_select_pin),
    .acknowledge_strobe(acknowledge_strobe), .cascade_id_in(cascade_id_in),
    .cascade_id_out(cascade_id_out), .cascade_id_oe(cascade_id_oe), .ack_data(ack_data),
    .ack_data_oe(ack_data_oe), .int_out(int_out)
);

/* File: tb/cip_cascade_peer.sv */
`timescale 1ns/10ps

// another master on the shared cascade lines, answering after a lag
module cip_cascade_peer #(
    parameter int LAG = 3
) (
    input wire logic core_clk, // clock
    input wire logic drive_req, // bench asks peer to drive
    input wire logic [2:0] drive_id, // slave id to drive
    input wire logic [2:0] dut_out, // dut drive value
    input wire logic dut_oe, // dut drive enable
    output logic [2:0] line_lvl // resolved cascade lines
);
    logic [7:0] hist_ff = 8'h00;
    logic [2:0] junk_ff = 3'h5;
    always_ff @(posedge core_clk) begin
        hist_ff <= {hist_ff[6:0], drive_req};
        junk_ff <= ~junk_ff;
    end
    // undriven lines toggle so a stale id can never match by accident
    assign line_lvl = dut_oe ? dut_out : (hist_ff[LAG-1] ? drive_id : junk_ff);
endmodule

/* File: tb/tb_cip_poll_cascade.sv */
`timescale 1ns/10ps

module tb_cip_poll_cascade;
    typedef struct packed {
        logic w;
        logic [11:0] a;
        logic [7:0] d;
        logic [7:0] x;
        logic e;
    } cip_row_t;
    localparam logic [2:0] VL = 3'h5;
    localparam logic [7:0] VH = 8'h40;
    localparam logic [11:0] CMD = cip_pkg::OFF_CMD;
    localparam logic [11:0] MSK = cip_pkg::OFF_MASK;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] request_input = 8'h00;
    logic master_select_pin = 1'b1;
    logic acknowledge_strobe = 1'b0;
    logic peer_req = 1'b0;
    logic [2:0] peer_id = 3'h0;
    logic [31:0] prdata;
    logic pready, pslverr, cascade_id_oe, ack_data_oe, int_out;
    logic [2:0] cascade_id_in, cascade_id_out;
    logic [7:0] ack_data;
    logic [31:0] rd;
    logic er;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    cip_row_t rows [17] = '{
        '{1'b1, CMD, {VL, 5'h12}, 8'h00, 1'b0}, '{1'b1, MSK, VH, 8'h00, 1'b0},
        '{1'b1, MSK, 8'h20, 8'h00, 1'b0}, '{1'b0, MSK, 8'h00, 8'h20, 1'b0},
        '{1'b1, CMD, 8'h0a, 8'h00, 1'b0}, '{1'b0, CMD, 8'h00, 8'h22, 1'b0},
        '{1'b0, CMD, 8'h00, 8'h22, 1'b0}, '{1'b1, CMD, 8'h0c, 8'h00, 1'b0},
        '{1'b0, CMD, 8'h00, 8'h81, 1'b0}, '{1'b0, CMD, 8'h00, 8'h20, 1'b0},
        '{1'b1, CMD, 8'h0b, 8'h00, 1'b0}, '{1'b0, CMD, 8'h00, 8'h02, 1'b0},
        '{1'b1, CMD, 8'h20, 8'h00, 1'b0}, '{1'b0, CMD, 8'h00, 8'h00, 1'b0},
        '{1'b1, CMD, 8'h0c, 8'h00, 1'b0}, '{1'b0, CMD, 8'h00, 8'h07, 1'b0},
        '{1'b0, 12'h008, 8'h00, 8'h00, 1'b1}
    };

    always #5 core_clk = ~core_clk;

    cip_poll_cascade dut (
        .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .request_input(request_input), .master_select_pin(master_select_pin),
        .acknowledge_strobe(acknowledge_strobe), .cascade_id_in(cascade_id_in),
        .cascade_id_out(cascade_id_out), .cascade_id_oe(cascade_id_oe), .ack_data(ack_data),
        .ack_data_oe(ack_data_oe), .int_out(int_out)
    );
    cip_cascade_peer #(.LAG(3)) peer (
        .core_clk(core_clk), .drive_req(peer_req), .drive_id(peer_id),
        .dut_out(cascade_id_out), .dut_oe(cascade_id_oe), .line_lvl(cascade_id_in)
    );

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
            n_mismatch++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // holds the request until ready is seen at an edge; one idle cycle follows
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        // ends when ready is seen; only the bench timeout ends a wait that never sees it
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk(nm, {24'h0, x}, rd);
    endtask
    task automatic ack3(input logic [2:0] en, input logic [23:0] bs);
        for (int i = 0; i < 3; i++) begin
            acknowledge_strobe <= 1'b1;
            @(posedge core_clk);
            acknowledge_strobe <= 1'b0;
            @(posedge core_clk);
            chk("ack_oe", {31'h0, en[i]}, {31'h0, ack_data_oe});
            if (en[i]) chk("ack_byte", {24'h0, bs[23-8*i -: 8]}, {24'h0, ack_data});
        end
    endtask
    task automatic pulse_req3;
        request_input <= 8'h22;
        tick(1);
        request_input <= 8'h2a;
        tick(3);
    endtask
    task automatic wrap_up;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge core_clk);
        chk("rst_outs", 32'h0, {8'h0, prdata[7:0], pready, pslverr, cascade_id_oe,
            ack_data_oe, int_out, cascade_id_out, ack_data});
        reset <= 1'b0;
        @(posedge core_clk);
        request_input <= 8'h22;
        rchk("mask_rst", MSK, cip_pkg::RST_MASK);
        // each poll read is preceded by its own poll write
        for (int i = 0; i < 17; i++) begin
            string nm;
            nm = $sformatf("row%0d", i);
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk({nm, "_err"}, {31'h0, rows[i].e}, {31'h0, er});
            if (!rows[i].w) chk(nm, {24'h0, rows[i].x}, rd);
        end
        // vectored acknowledge after polling, single mode
        request_input <= 8'h2a;
        tick(3);
        chk("int_vec", 32'h1, {31'h0, int_out});
        ack3(3'b111, {cip_pkg::CALL_OPCODE, VL, 3'h3, 2'b00, VH});
        wr(CMD, 8'h0b);
        rchk("svc_vec", CMD, 8'h08);
        // cascade master with slaves on inputs 3 and 6
        wr(CMD, {VL, 5'h10});
        wr(MSK, VH);
        wr(MSK, 8'h48);
        pulse_req3();
        ack3(3'b001, {cip_pkg::CALL_OPCODE, 16'h0});
        chk("casc_id", 32'h3, {29'h0, cascade_id_out});
        chk("casc_oe", 32'h1, {31'h0, cascade_id_oe});
        pulse_req3();
        chk("int_block", 32'h0, {31'h0, int_out});
        // slave with identity 3; the peer drives the lines late
        master_select_pin <= 1'b0;
        peer_id <= 3'h3;
        peer_req <= 1'b1;
        wr(CMD, {VL, 5'h10});
        wr(MSK, VH);
        wr(MSK, 8'h03);
        chk("int_slv", 32'h1, {31'h0, int_out});
        chk("slv_oe", 32'h0, {31'h0, cascade_id_oe});
        ack3(3'b110, {8'h00, VL, 3'h3, 2'b00, VH});
        wr(CMD, 8'h0b);
        rchk("svc_slv", CMD, 8'h08);
        wr(CMD, 8'h63);
        rchk("svc_eos", CMD, 8'h00);
        peer_id <= 3'h6;
        ack3(3'b000, 24'h0);
        // a second reset mid-run must restore the request read selection
        reset <= 1'b1;
        tick(2);
        reset <= 1'b0;
        tick(1);
        chk("rst_mid", 32'h0, {8'h0, prdata[7:0], pready, pslverr, cascade_id_oe,
            ack_data_oe, int_out, cascade_id_out, ack_data});
        rchk("sel_mid", CMD, 8'h2a);
        wrap_up();
    end
endmodule
